/* core/ddmp_cmd_dec.sv */
module ddmp_cmd_dec
  import ddmp_pkg::*;
(
  // Sampled pins
  input  wire ddmp_ca_t ca,
  input  wire logic     cke_prev,
  // Decoded command
  output ddmp_cmd_e     cmd
);

  // ==========================================================
  // Decode from chip select, strobes and both CKE samples
  always_comb begin
    cmd = DDMP_CMD_NOP;
    if (cke_prev && !ca.cke) begin
      // CKE falling: power-down or self-refresh entry
      cmd = DDMP_CMD_PDN;
    end else if (!cke_prev) begin
      // Clock disabled, nothing registered
      cmd = DDMP_CMD_NOP;
    end else if (ca.cs_n) begin
      // Deselect
      cmd = DDMP_CMD_NOP;
    end else begin
      case ({ca.ras_n, ca.cas_n, ca.we_n})
        3'h0: cmd = DDMP_CMD_MRS;
        3'h5: cmd = ca.a[10] ? DDMP_CMD_RDA : DDMP_CMD_RD;
        3'h4: cmd = ca.a[10] ? DDMP_CMD_WRA : DDMP_CMD_WR;
        3'h7: cmd = DDMP_CMD_NOP;
        default: cmd = DDMP_CMD_OTHER;
      endcase
    end
  end

endmodule

/* core/ddmp_mpr_top.sv */
`include "ddmp_defines.svh"

module ddmp_mpr_top
  import ddmp_pkg::*;
(
  // Clock and reset
  input  wire logic          SYS_CLK,
  input  wire logic          RESET,
  // External device reset pin, active low
  input  wire logic          DRAM_RESET_N,
  // Command and address bus
  input  wire ddmp_ca_t      CA_IN,
  // Read data pins
  output logic [15:0]        DQ_OUT,
  output logic               DQ_OE_N,
  // Array side
  output logic               ARRAY_RD,
  output logic               ARRAY_WR,
  output logic               ARRAY_PRE,
  output logic [2:0]         ARRAY_BANK,
  output logic [9:0]         ARRAY_COL,
  input  wire logic [15:0]   ARRAY_RDATA,
  // Termination control
  output logic [1:0]         RTT_WR,
  output logic               ODT_DYN,
  // APB slave
  input  wire ddmp_apb_req_t APB_REQ,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR
);

  // ==========================================================
  // Declarations
  ddmp_state_t   st_q;        // Registered state
  ddmp_state_t   st_d;        // Next state
  ddmp_cmd_e     cmd;         // Decoded command this cycle
  logic          pin_rst_n;   // Filtered external reset
  ddmp_rd_slot_t new_slot;    // Read entering the pipe
  ddmp_rd_slot_t tap;         // Read whose latency has elapsed
  ddmp_rd_slot_t cur;         // Slot of the beat being driven
  logic [3:0]    tap_idx;     // Pipe position of latency tap
  logic [2:0]    p;           // Burst position of this beat
  logic [3:0]    n;           // Beats left including this one
  logic          beat;        // A beat is driven next cycle
  logic          bit_v;       // MPR bit for this beat
  logic [7:0]    lane;        // One byte lane of MPR data
  logic [7:0]    cal_pat;     // Calibration bits, one per beat
  logic          set_ill;     // Illegal command seen
  logic          apb_acc;     // Access phase, answer pending
  logic          apb_wr;      // Write completes this edge
  logic          is_mr3;      // MRS targets MR3
  logic [31:0]   rd_val;      // Read value for the address
  logic          rd_err;      // Unmapped address

  // ==========================================================
  // External reset pin synchroniser
  ddmp_sync3 #(
    .RST_VAL (1'b1)
  ) u_rst_sync (
    .clk (SYS_CLK),
    .rst (RESET),
    .d   (DRAM_RESET_N),
    .q   (pin_rst_n)
  );

  // ==========================================================
  // Command decoder
  ddmp_cmd_dec u_dec (
    .ca       (CA_IN),
    .cke_prev (st_q.cke_prev),
    .cmd      (cmd)
  );

  // ==========================================================
  // APB read mux and address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (APB_REQ.paddr == `DDMP_OFS_CTRL) begin
      rd_val[`DDMP_CTRL_RL_MSB:`DDMP_CTRL_RL_LSB] = st_q.rd_lat;
      rd_val[`DDMP_CTRL_COPY_BIT] = st_q.dq_copy;
      rd_val[`DDMP_CTRL_X16_BIT]  = st_q.x16;
    end else if (APB_REQ.paddr == `DDMP_OFS_STATUS) begin
      rd_val[`DDMP_ST_MPR_BIT] = (st_q.mode == DDMP_MODE_MPR);
      rd_val[`DDMP_ST_LOC_MSB:`DDMP_ST_LOC_LSB] = st_q.mr3_loc;
      rd_val[`DDMP_ST_WRLVL_BIT] = st_q.mr1_wrlvl;
      rd_val[`DDMP_ST_RTT_MSB:`DDMP_ST_RTT_LSB] = st_q.mr2_rtt_wr;
      rd_val[`DDMP_ST_BL_MSB:`DDMP_ST_BL_LSB] = st_q.mr0_bl;
      rd_val[`DDMP_ST_BURST_BIT] = !st_q.dq_oe_n;
    end else if (APB_REQ.paddr == `DDMP_OFS_ERR) begin
      rd_val[`DDMP_ERR_ILL_BIT] = st_q.err_ill;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ==========================================================
  // Read slot built from the sampled address
  always_comb begin
    new_slot     = '0;
    new_slot.vld = (cmd == DDMP_CMD_RD) || (cmd == DDMP_CMD_RDA);
    new_slot.mpr = (st_q.mode == DDMP_MODE_MPR);
    new_slot.loc = st_q.mr3_loc;
    // Burst chop from MR0, or from A12 when on-the-fly
    new_slot.bc4 = (st_q.mr0_bl == `DDMP_BL_BC4)
                || ((st_q.mr0_bl == `DDMP_BL_OTF)
                    && !CA_IN.a[`DDMP_A_BC_BIT]);
    // Only A2 picks the nibble; the rest is ignored
    new_slot.nib = new_slot.bc4 && CA_IN.a[`DDMP_A_NIB_BIT];
  end

  // ==========================================================
  // Latency tap, same pipe for array and MPR reads
  always_comb begin
    tap_idx = (st_q.rd_lat == 4'h0) ? 4'h0 : (st_q.rd_lat - 4'h1);
    tap     = st_q.rd_pipe[tap_idx];
  end

  // ==========================================================
  // Beat generation
  always_comb begin
    cur  = st_q.burst;
    p    = st_q.pos;
    n    = st_q.left;
    beat = 1'b0;
    if (tap.vld) begin
      // New burst starts, overriding any tail
      cur  = tap;
      p    = {tap.nib, 2'h0};
      n    = tap.bc4 ? `DDMP_LEN_BC4 : `DDMP_LEN_BL8;
      beat = 1'b1;
    end else if (st_q.left != 4'h0) begin
      beat = 1'b1;
    end
    // Calibration location; reserved ones read zero
    cal_pat = `DDMP_CAL_PATTERN;
    bit_v = (cur.loc == `DDMP_LOC_CAL) ? cal_pat[p] : 1'b0;
    // Lane 0 carries the bit, the rest copy or drive zero
    lane = {st_q.dq_copy ? {7{bit_v}} : 7'h00, bit_v};
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_d         = st_q;
    st_d.arr_rd  = 1'b0;
    st_d.arr_wr  = 1'b0;
    st_d.arr_pre = 1'b0;
    set_ill      = 1'b0;
    is_mr3       = (CA_IN.ba == `DDMP_MR3);
    st_d.cke_prev = CA_IN.cke;

    // Read pipe shifts every cycle
    st_d.rd_pipe = {st_q.rd_pipe[14:0], ddmp_rd_slot_t'('0)};

    // Command handling per mode
    case (st_q.mode)
      DDMP_MODE_NORMAL: begin
        if (cmd == DDMP_CMD_MRS) begin
          if (CA_IN.ba == `DDMP_MR0) begin
            st_d.mr0_bl = CA_IN.a[`DDMP_A_BL_MSB:`DDMP_A_BL_LSB];
          end else if (CA_IN.ba == `DDMP_MR1) begin
            st_d.mr1_wrlvl = CA_IN.a[`DDMP_A_WRLVL_BIT];
          end else if (CA_IN.ba == `DDMP_MR2) begin
            st_d.mr2_rtt_wr =
              CA_IN.a[`DDMP_A_RTT_MSB:`DDMP_A_RTT_LSB];
          end else if (is_mr3) begin
            st_d.mr3_loc = CA_IN.a[`DDMP_A_LOC_MSB:`DDMP_A_LOC_LSB];
            if (CA_IN.a[`DDMP_A_MPR_BIT]) begin
              // Banks assumed idle on entry
              st_d.mode = DDMP_MODE_MPR;
            end
          end
        end else if (new_slot.vld) begin
          // Array read, with auto precharge on RDA
          st_d.rd_pipe[0] = new_slot;
          st_d.arr_rd     = 1'b1;
          st_d.arr_pre    = (cmd == DDMP_CMD_RDA);
          st_d.arr_bank   = CA_IN.ba;
          st_d.arr_col    = CA_IN.a[9:0];
        end else if ((cmd == DDMP_CMD_WR)
                  || (cmd == DDMP_CMD_WRA)) begin
          // Array write opens the write termination window
          st_d.arr_wr   = 1'b1;
          st_d.arr_pre  = (cmd == DDMP_CMD_WRA);
          st_d.arr_bank = CA_IN.ba;
          st_d.arr_col  = CA_IN.a[9:0];
          st_d.wr_win   = `DDMP_WR_WIN_CYC;
        end
      end
      DDMP_MODE_MPR: begin
        if ((cmd == DDMP_CMD_MRS) && is_mr3) begin
          st_d.mr3_loc = CA_IN.a[`DDMP_A_LOC_MSB:`DDMP_A_LOC_LSB];
          if (!CA_IN.a[`DDMP_A_MPR_BIT]) begin
            st_d.mode = DDMP_MODE_NORMAL;
          end
        end else if (new_slot.vld) begin
          // RDA acts as RD: no precharge, no array access
          st_d.rd_pipe[0] = new_slot;
        end else if (cmd != DDMP_CMD_NOP) begin
          // Anything else is flagged and dropped
          set_ill = 1'b1;
        end
      end
      default: begin
        st_d.mode = DDMP_MODE_NORMAL;
      end
    endcase

    // Data pins
    if (beat) begin
      st_d.burst   = cur;
      st_d.pos     = p + 3'h1;
      st_d.left    = n - 4'h1;
      st_d.dq_oe_n = 1'b0;
      if (cur.mpr) begin
        st_d.dq_out = {st_q.x16 ? lane : 8'h00, lane};
      end else begin
        st_d.dq_out = ARRAY_RDATA;
      end
    end else begin
      st_d.dq_out  = 16'h0000;
      st_d.dq_oe_n = 1'b1;
    end

    // Write termination window and dynamic selection
    if (!(st_d.arr_wr) && (st_q.wr_win != 4'h0)) begin
      st_d.wr_win = st_q.wr_win - 4'h1;
    end
    st_d.odt_dyn = (st_d.wr_win != 4'h0) && !st_q.mr1_wrlvl
                && (st_q.mr2_rtt_wr != `DDMP_RTT_OFF);

    // APB: answer one cycle into the access phase
    apb_acc      = APB_REQ.psel && APB_REQ.penable;
    apb_wr       = apb_acc && st_q.pready && APB_REQ.pwrite;
    st_d.pready  = apb_acc && !st_q.pready;
    st_d.pslverr = apb_acc && !st_q.pready && rd_err;
    st_d.prdata  = (apb_acc && !st_q.pready && !APB_REQ.pwrite)
                 ? rd_val : 32'h0000_0000;
    if (apb_wr && !st_q.pslverr) begin
      if (APB_REQ.paddr == `DDMP_OFS_CTRL) begin
        st_d.rd_lat =
          APB_REQ.pwdata[`DDMP_CTRL_RL_MSB:`DDMP_CTRL_RL_LSB];
        st_d.dq_copy = APB_REQ.pwdata[`DDMP_CTRL_COPY_BIT];
        st_d.x16     = APB_REQ.pwdata[`DDMP_CTRL_X16_BIT];
      end else if (APB_REQ.paddr == `DDMP_OFS_ERR) begin
        if (APB_REQ.pwdata[`DDMP_ERR_ILL_BIT]) begin
          st_d.err_ill = 1'b0;
        end
      end
    end
    // A new error wins over a clear in the same cycle
    if (set_ill) begin
      st_d.err_ill = 1'b1;
    end

    // External reset pin returns device state, even in MPR mode
    if (!pin_rst_n) begin
      st_d.mode       = DDMP_MODE_NORMAL;
      st_d.mr0_bl     = `DDMP_BL_FIX8;
      st_d.mr1_wrlvl  = 1'b0;
      st_d.mr2_rtt_wr = `DDMP_RTT_OFF;
      st_d.mr3_loc    = `DDMP_LOC_CAL;
      st_d.rd_pipe    = '0;
      st_d.left       = 4'h0;
      st_d.wr_win     = 4'h0;
      st_d.odt_dyn    = 1'b0;
      st_d.arr_rd     = 1'b0;
      st_d.arr_wr     = 1'b0;
      st_d.arr_pre    = 1'b0;
      st_d.dq_out     = 16'h0000;
      st_d.dq_oe_n    = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_q            <= '0;
      st_q.mode       <= DDMP_MODE_NORMAL;
      st_q.rd_lat     <= `DDMP_RL_RST;
      st_q.dq_copy    <= `DDMP_COPY_RST;
      st_q.x16        <= `DDMP_X16_RST;
      st_q.dq_oe_n    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs straight from state
  assign DQ_OUT     = st_q.dq_out;
  assign DQ_OE_N    = st_q.dq_oe_n;
  assign ARRAY_RD   = st_q.arr_rd;
  assign ARRAY_WR   = st_q.arr_wr;
  assign ARRAY_PRE  = st_q.arr_pre;
  assign ARRAY_BANK = st_q.arr_bank;
  assign ARRAY_COL  = st_q.arr_col;
  assign RTT_WR     = st_q.mr2_rtt_wr;
  assign ODT_DYN    = st_q.odt_dyn;
  assign PRDATA     = st_q.prdata;
  assign PREADY     = st_q.pready;
  assign PSLVERR    = st_q.pslverr;

endmodule

/* core/ddmp_sync3.sv */
module ddmp_sync3
  import ddmp_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, filtered level out
  input  wire logic d,
  output logic      q
);

  // ==========================================================
  // State
  ddmp_sync_st_t st_q;  // Registered state
  ddmp_sync_st_t st_d;  // Next state

  // Shift the level in; accept it once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.q = st_q.s3;
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;

endmodule

/* pkg/ddmp_defines.svh */
`ifndef DDMP_DEFINES_SVH
`define DDMP_DEFINES_SVH

// ==========================================================
// Register map (byte addresses on APB)
`define DDMP_OFS_CTRL        8'h00
`define DDMP_OFS_STATUS      8'h04
`define DDMP_OFS_ERR         8'h08

// ==========================================================
// CTRL fields
`define DDMP_CTRL_RL_LSB     0
`define DDMP_CTRL_RL_MSB     3
`define DDMP_CTRL_COPY_BIT   8
`define DDMP_CTRL_X16_BIT    9
`define DDMP_RL_RST          4'h5
`define DDMP_COPY_RST        1'b1
`define DDMP_X16_RST         1'b0

// ==========================================================
// STATUS and ERR fields
`define DDMP_ST_MPR_BIT      0
`define DDMP_ST_LOC_LSB      1
`define DDMP_ST_LOC_MSB      2
`define DDMP_ST_WRLVL_BIT    3
`define DDMP_ST_RTT_LSB      4
`define DDMP_ST_RTT_MSB      5
`define DDMP_ST_BL_LSB       6
`define DDMP_ST_BL_MSB       7
`define DDMP_ST_BURST_BIT    8
`define DDMP_ERR_ILL_BIT     0

// ==========================================================
// Mode register selection and address bit positions
`define DDMP_MR0             3'h0
`define DDMP_MR1             3'h1
`define DDMP_MR2             3'h2
`define DDMP_MR3             3'h3
`define DDMP_A_BL_LSB        0
`define DDMP_A_BL_MSB        1
`define DDMP_A_LOC_LSB       0
`define DDMP_A_LOC_MSB       1
`define DDMP_A_MPR_BIT       2
`define DDMP_A_NIB_BIT       2
`define DDMP_A_WRLVL_BIT     7
`define DDMP_A_RTT_LSB       9
`define DDMP_A_RTT_MSB       10
`define DDMP_A_BC_BIT        12

// ==========================================================
// Burst and pattern constants
`define DDMP_BL_FIX8         2'h0
`define DDMP_BL_OTF          2'h1
`define DDMP_BL_BC4          2'h2
`define DDMP_LOC_CAL         2'h0
`define DDMP_CAL_PATTERN     8'hAA
`define DDMP_LEN_BL8         4'h8
`define DDMP_LEN_BC4         4'h4
`define DDMP_WR_WIN_CYC      4'h8
`define DDMP_PIPE_DEPTH      16
`define DDMP_RTT_OFF         2'h0

`endif

/* pkg/ddmp_pkg.sv */
package ddmp_pkg;

  // ========================================================
  // Command/address pins as sampled on a rising edge
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] a;
  } ddmp_ca_t;

  // APB request side
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ddmp_apb_req_t;

  // ========================================================
  // Decoded commands
  typedef enum logic [2:0] {
    DDMP_CMD_NOP   = 3'h0,
    DDMP_CMD_MRS   = 3'h1,
    DDMP_CMD_RD    = 3'h2,
    DDMP_CMD_RDA   = 3'h3,
    DDMP_CMD_WR    = 3'h4,
    DDMP_CMD_WRA   = 3'h5,
    DDMP_CMD_OTHER = 3'h6,
    DDMP_CMD_PDN   = 3'h7
  } ddmp_cmd_e;

  // Device mode, one-hot
  typedef enum logic [1:0] {
    DDMP_MODE_NORMAL = 2'h1,
    DDMP_MODE_MPR    = 2'h2
  } ddmp_mode_e;

  // One read waiting for its latency to elapse
  typedef struct packed {
    logic       vld;
    logic       mpr;
    logic       bc4;
    logic       nib;
    logic [1:0] loc;
  } ddmp_rd_slot_t;

  // Synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ddmp_sync_st_t;

  // Whole state of the top module
  typedef struct packed {
    ddmp_mode_e                           mode;
    logic                                 cke_prev;
    logic [1:0]                           mr0_bl;
    logic                                 mr1_wrlvl;
    logic [1:0]                           mr2_rtt_wr;
    logic [1:0]                           mr3_loc;
    logic [3:0]                           rd_lat;
    logic                                 dq_copy;
    logic                                 x16;
    logic                                 err_ill;
    ddmp_rd_slot_t [15:0]                 rd_pipe;
    ddmp_rd_slot_t                        burst;
    logic [2:0]                           pos;
    logic [3:0]                           left;
    logic                                 arr_rd;
    logic                                 arr_pre;
    logic                                 arr_wr;
    logic [2:0]                           arr_bank;
    logic [9:0]                           arr_col;
    logic [3:0]                           wr_win;
    logic                                 odt_dyn;
    logic [15:0]                          dq_out;
    logic                                 dq_oe_n;
    logic                                 pready;
    logic                                 pslverr;
    logic [31:0]                          prdata;
  } ddmp_state_t;

endpackage

/* verif/ddmp_ctl_model.sv */
// ========================================
// Command-bus model of the memory controller
module ddmp_ctl_model
  import ddmp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command and address pins
  output ddmp_ca_t  ca
);
  timeunit 1ns;
  timeprecision 1ns;
  // Deselected, clock enable kept high
  initial ca = {1'b1, 1'b1, 3'h7, 3'h0, 14'h0};
  // One command at a rising edge, then deselect
  task automatic send(input logic [2:0] rcw, input logic [2:0] ba,
                      input logic [13:0] a);
    @(posedge clk);
    ca <= {1'b1, 1'b0, rcw, ba, a};
    @(posedge clk);
    ca.cs_n <= 1'b1;
    ca.ba <= ~ba; // Idle lines do not keep old value
    ca.a <= ~a;
  endtask
  // MR3 write; banks are never opened, so all idle
  task automatic mrs3(input logic en, input logic [1:0] loc);
    send(3'b000, 3'h3, {11'h0, en, loc});
  endtask
  // Read with column A1:A0 zero and junk in ignored bits
  task automatic rd(input logic a12, input logic nib, input logic rda);
    send(3'b101, 3'h5, {1'b0, a12, 1'b0, rda, 7'h55, nib, 2'b00});
  endtask
endmodule

/* verif/ddmp_mpr_props.sv */
// ========================================
// Checker for the MPR readout top
module ddmp_mpr_props
  import ddmp_pkg::*;
(
  // Clock and resets
  input wire logic          SYS_CLK,
  input wire logic          RESET,
  input wire logic          DRAM_RESET_N,
  // Command bus and read pins
  input wire ddmp_ca_t      CA_IN,
  input wire logic [15:0]   DQ_OUT,
  input wire logic          DQ_OE_N,
  // Array strobes and termination
  input wire logic          ARRAY_RD,
  input wire logic          ARRAY_PRE,
  input wire logic [1:0]    RTT_WR,
  input wire logic          ODT_DYN,
  // Register bus
  input wire ddmp_apb_req_t APB_REQ,
  input wire logic          PREADY,
  input wire logic          PSLVERR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic       cke_q;  // Clock enable one edge back
  logic       mpr_q;  // Shadow of MPR mode
  logic       wl_q;   // Shadow of write leveling
  logic [1:0] loc_q;  // Shadow of MPR location
  logic       live;   // Selected with clock enabled
  logic       mrs;    // Mode register set seen
  logic       rd;     // Read seen
  // Decode of the sampled pins
  assign live = CA_IN.cke & cke_q & ~CA_IN.cs_n;
  assign mrs = live & ~CA_IN.ras_n & ~CA_IN.cas_n & ~CA_IN.we_n;
  assign rd = live & CA_IN.ras_n & ~CA_IN.cas_n & CA_IN.we_n;
  // Shadow copies of the mode bits
  always_ff @(posedge SYS_CLK) begin
    cke_q <= CA_IN.cke;
    if (RESET || !DRAM_RESET_N) begin
      mpr_q <= 1'b0;
      wl_q <= 1'b0;
      loc_q <= 2'h0;
    end else if (mrs && CA_IN.ba == 3'h3) begin
      mpr_q <= CA_IN.a[2];
      loc_q <= CA_IN.a[1:0];
    end else if (mrs && CA_IN.ba == 3'h1 && !mpr_q) begin
      wl_q <= CA_IN.a[7];
    end
  end
  rtt_from_mr2_a: assert property (
    mrs && CA_IN.ba == 3'h2 && !mpr_q |=> ##1
    RTT_WR == $past(CA_IN.a[10:9], 2)) else $error("rtt not from mr2");
  wrlvl_no_dyn_a: assert property (
    wl_q && $past(wl_q) |-> !ODT_DYN) else $error("dynamic odt in wrlvl");
  normal_array_a: assert property (
    rd && !mpr_q |=> ARRAY_RD) else $error("normal read missed array");
  mpr_no_array_a: assert property (
    rd && mpr_q |=> !ARRAY_RD && !ARRAY_PRE) else $error("mpr hit array");
  read_latency_a: assert property (
    rd |-> ##5 DQ_OE_N ##1 !DQ_OE_N) else $error("read latency wrong");
  cal_pattern_a: assert property (
    rd && mpr_q && loc_q == 2'h0 |-> ##6 DQ_OUT[0] == 1'b0 ##1
    DQ_OUT[0] == 1'b1) else $error("calibration pattern wrong");
  lane_copy_a: assert property (
    !DQ_OE_N && mpr_q |-> (DQ_OUT[7:1] == {7{DQ_OUT[0]}} ||
    DQ_OUT[7:1] == 7'h0) && (DQ_OUT[15:8] == DQ_OUT[7:0] ||
    DQ_OUT[15:8] == 8'h0)) else $error("lane copy wrong");
  apb_answer_a: assert property (
    APB_REQ.psel && $rose(APB_REQ.penable) |=> PREADY)
    else $error("apb answer late");
  ready_pulse_a: assert property (
    PREADY |=> !PREADY) else $error("pready too long");
  err_ready_a: assert property (
    PSLVERR |-> PREADY) else $error("pslverr without pready");
  cover property (rd && mpr_q);
  cover property (ODT_DYN);
  cover property (PSLVERR);
endmodule

bind ddmp_mpr_top ddmp_mpr_props u_props (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .DRAM_RESET_N(DRAM_RESET_N),
  .CA_IN(CA_IN), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N),
  .ARRAY_RD(ARRAY_RD), .ARRAY_PRE(ARRAY_PRE), .RTT_WR(RTT_WR),
  .ODT_DYN(ODT_DYN), .APB_REQ(APB_REQ), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

/* verif/ddr3_mpr_readout_mode_tb_top.sv */
`include "ddmp_defines.svh"
// ========================================
// Bench for the MPR readout top
module ddr3_mpr_readout_mode_tb_top import ddmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: location, MR0 burst field, a12 nib rda copy x16, len, bits
  typedef struct packed {
    logic [1:0] loc;
    logic [1:0] bl;
    logic [4:0] f;
    logic [3:0] len;
    logic [7:0] bits;
  } ddmp_row_t;
  ddmp_row_t rows [8] = '{
    {2'h0, 2'h0, 5'b00010, 4'h8, 8'hAA}, {2'h0, 2'h2, 5'b10101, 4'h4, 8'h0A},
    {2'h0, 2'h2, 5'b11011, 4'h4, 8'h0A}, {2'h0, 2'h1, 5'b01110, 4'h4, 8'h0A},
    {2'h0, 2'h1, 5'b10000, 4'h8, 8'hAA}, {2'h1, 2'h0, 5'b00111, 4'h8, 8'h00},
    {2'h2, 2'h2, 5'b11001, 4'h4, 8'h00}, {2'h3, 2'h1, 5'b10110, 4'h8, 8'h00}};
  logic          clk, rst, dram_rst_n, dq_oe_n, pready, pslverr, odt, rerr;
  logic [15:0]   arr_rdata, dq;
  logic [1:0]    rtt;
  logic [2:0]    arr_bank;
  logic [9:0]    arr_col;
  logic          arr_wr;
  logic [31:0]   prdata, rdata;
  ddmp_apb_req_t apb;
  ddmp_ca_t      ca;
  int            miscompares, n_tests;
  // Controller model and device
  ddmp_ctl_model ctl (.clk(clk), .ca(ca));
  ddmp_mpr_top uut (
    .SYS_CLK(clk), .RESET(rst), .DRAM_RESET_N(dram_rst_n), .CA_IN(ca),
    .DQ_OUT(dq), .DQ_OE_N(dq_oe_n), .ARRAY_RD(), .ARRAY_WR(arr_wr),
    .ARRAY_PRE(), .ARRAY_BANK(arr_bank), .ARRAY_COL(arr_col),
    .ARRAY_RDATA(arr_rdata),
    .RTT_WR(rtt), .ODT_DYN(odt), .APB_REQ(apb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // One compare
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, answer taken where pready is high
  task automatic apb_xfer(input logic wr, input logic [7:0] ad,
                          input logic [31:0] wd);
    @(posedge clk);
    apb <= {1'b1, 1'b0, wr, ad, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    // Hold until pready is seen high at an edge; watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  // Collect nine cycles: one burst and the idle cycles after it
  task automatic grab(input ddmp_row_t r);
    logic [7:0] ln;
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 9; i++) begin
      ln = r.f[1] ? {8{r.bits[i%8]}} : {7'h0, r.bits[i%8]};
      chk("dq_oe_n", {31'h0, i >= r.len}, {31'h0, dq_oe_n});
      if (i < r.len) begin
        chk("dq", {16'h0, r.f[0] ? ln : 8'h0, ln}, {16'h0, dq});
      end
      @(posedge clk);
      #1;
    end
  endtask
  // Verdict
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    dram_rst_n = 1'b1;
    arr_rdata = 16'h5A3C;
    apb = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("oe_rst", 32'h1, {31'h0, dq_oe_n});
    chk("rtt_rst", 32'h0, {30'h0, rtt});
    apb_xfer(1'b0, `DDMP_OFS_CTRL, 32'h0);
    chk("ctrl_rst", 32'h105, rdata);
    apb_xfer(1'b0, 8'h0C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdata);
    // Table of MPR reads
    foreach (rows[k]) begin
      apb_xfer(1'b1, `DDMP_OFS_CTRL,
               {22'h0, rows[k].f[0], rows[k].f[1], 8'h05});
      ctl.send(3'b000, 3'h3, 14'h0);
      ctl.send(3'b000, 3'h0, {12'h0, rows[k].bl});
      ctl.mrs3(1'b1, rows[k].loc);
      ctl.rd(rows[k].f[4], rows[k].f[3], rows[k].f[2]);
      grab(rows[k]);
    end
    // Normal read after leaving MPR
    ctl.send(3'b000, 3'h3, 14'h0);
    ctl.rd(1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    #1;
    chk("arr_beat", 32'h3C, {24'h0, dq[7:0]});
    chk("arr_bank", 32'h5, {29'h0, arr_bank});
    chk("arr_col", 32'h2A8, {22'h0, arr_col});
    // Write termination, then write leveling
    ctl.send(3'b000, 3'h2, 14'h0200);
    ctl.send(3'b100, 3'h0, 14'h0);
    #1;
    chk("rtt", 32'h1, {30'h0, rtt});
    chk("odt_dyn", 32'h1, {31'h0, odt});
    chk("arr_wr", 32'h1, {31'h0, arr_wr});
    repeat (10) @(posedge clk);
    ctl.send(3'b000, 3'h1, 14'h0080);
    ctl.send(3'b100, 3'h0, 14'h0);
    #1;
    chk("odt_wrlvl", 32'h0, {31'h0, odt});
    apb_xfer(1'b0, `DDMP_OFS_STATUS, 32'h0);
    chk("status_odt", 32'h18, rdata & 32'h38);
    ctl.send(3'b000, 3'h1, 14'h0);
    // Refused write in MPR mode
    ctl.mrs3(1'b1, 2'h0);
    ctl.send(3'b100, 3'h0, 14'h0);
    #1;
    chk("mpr_wr_drop", 32'h0, {31'h0, arr_wr});
    apb_xfer(1'b0, `DDMP_OFS_ERR, 32'h0);
    chk("err_set", 32'h1, rdata);
    apb_xfer(1'b1, `DDMP_OFS_ERR, 32'h1);
    apb_xfer(1'b0, `DDMP_OFS_ERR, 32'h0);
    chk("err_clr", 32'h0, rdata);
    // Device reset pin while in MPR mode
    apb_xfer(1'b0, `DDMP_OFS_STATUS, 32'h0);
    chk("mpr_on", 32'h1, rdata & 32'h1);
    dram_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    dram_rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    apb_xfer(1'b0, `DDMP_OFS_STATUS, 32'h0);
    chk("mpr_reset", 32'h0, rdata & 32'h1);
    chk("rtt_pin_rst", 32'h0, {30'h0, rtt});
    print_verdict();
  end
endmodule
